// ===== core/sacs_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH

`define SACS_ADDR_W           6
`define SACS_OFS_CONV_SETUP   6'h0A
`define SACS_OFS_SUPPLY_RES   6'h0B
`define SACS_OFS_DEV_SETUP    6'h0C
`define SACS_CONV_SETUP_RST   16'hFF3A
`define SACS_CONV_RSVD        8'hFF
`define SACS_SUPPLY_RSVD      5'h1F
`define SACS_DEV_SETUP_RST    16'h0000
`define SACS_FLD_RATE_LO      6
`define SACS_FLD_DROP_OFF     5
`define SACS_FLD_OUTV_OFF     4
`define SACS_FLD_TEMP_OFF     3
`define SACS_FLD_CURR_OFF     2
`define SACS_FLD_SUPPLY_OFF   1
`define SACS_FLD_CONV_OFF     0
`define SACS_FLD_FLT_LATCH    0
`define SACS_FLD_FRESH        10
`define SACS_SLOT_NS          1000
`define SACS_CLK_NS           10
`define SACS_SLOT_CYC         (`SACS_SLOT_NS / `SACS_CLK_NS)
`define SACS_CNT_W            10

`endif

// ===== core/sacs_pkg.sv
// Types shared by the converter setup block
package sacs_pkg;

	typedef enum logic [2:0] {
		SACS_M_DROP,
		SACS_M_OUTV,
		SACS_M_TEMP,
		SACS_M_CURR,
		SACS_M_SUPPLY
	} sacs_meas_t;

	typedef struct packed {
		logic       conv_off;
		logic       drop_off;
		logic       outv_off;
		logic       temp_off;
		logic       curr_off;
		logic       supply_off;
		logic [1:0] rate_sel;
	} sacs_cfg_t;

	typedef struct packed {
		logic       valid;
		sacs_meas_t meas;
		logic [1:0] chan_mask;
	} sacs_conv_t;

endpackage : sacs_pkg

// ===== core/sacs_top.sv
// Converter sequence configuration, sequencer and global fault flag latching
// What this block does
// R1: Fault flags latch until read when 0h
// R2: Fault flags follow live condition when 1h
// R3: Rate select: 0,1 max; 2 half; 3 quarter
// R4: Drop sense global off excludes all channels
// R5: Channel off bits only act when global 0
// R6: Output voltage global off excludes all channels
// R7: Temperature controlled only by global bit
// R8: Current global off resets 0, excludes all
// R9: Supply off omits supply conversion, resets 1
// R10: Converter off stops all conversions
// R11: Supply fresh flag set on new result
// R12: Sequencer cycles enabled types, idles when off
`timescale 1ns/1ps
`include "sacs_defs.svh"

module sacs_top
	import sacs_pkg::*;
#(
	parameter int SLOT_CYC = `SACS_SLOT_CYC
) (
	input  wire logic                    mclk,
	input  wire logic                    rstn,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [`SACS_ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]             reg_wdata,
	output logic      [15:0]             reg_rdata,
	input  wire logic [1:0]              drop_sense_channel_off,
	input  wire logic [1:0]              outvolt_sense_channel_off,
	input  wire logic [1:0]              load_current_channel_off,
	input  wire logic [5:0]              fault_live,
	input  wire logic                    fault_flag_rd,
	input  wire logic                    conv_done,
	input  wire logic [9:0]              supply_result,
	output sacs_conv_t                   conv_req,
	output logic [5:0]                   fault_flags,
	output logic                         supply_result_fresh
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	sacs_cfg_t   cfg_reg;
	logic        fault_latch_disable_reg;
	logic [9:0]  supply_res_reg;
	logic        fresh_reg;
	logic [5:0]  flags_reg;

	wire logic wr_conv = reg_wr && reg_addr == `SACS_OFS_CONV_SETUP;
	wire logic wr_dev  = reg_wr && reg_addr == `SACS_OFS_DEV_SETUP;
	wire logic rd_sup  = reg_rd && reg_addr == `SACS_OFS_SUPPLY_RES;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg.rate_sel   <= 2'h0;
			cfg_reg.drop_off   <= 1'b1; // R4
			cfg_reg.outv_off   <= 1'b1; // R6
			cfg_reg.temp_off   <= 1'b1; // R7
			cfg_reg.curr_off   <= 1'b0; // R8
			cfg_reg.supply_off <= 1'b1; // R9
			cfg_reg.conv_off   <= 1'b0; // R10
		end else if (wr_conv) begin
			cfg_reg.rate_sel   <= reg_wdata[`SACS_FLD_RATE_LO +: 2];
			cfg_reg.drop_off   <= reg_wdata[`SACS_FLD_DROP_OFF];
			cfg_reg.outv_off   <= reg_wdata[`SACS_FLD_OUTV_OFF];
			cfg_reg.temp_off   <= reg_wdata[`SACS_FLD_TEMP_OFF];
			cfg_reg.curr_off   <= reg_wdata[`SACS_FLD_CURR_OFF];
			cfg_reg.supply_off <= reg_wdata[`SACS_FLD_SUPPLY_OFF];
			cfg_reg.conv_off   <= reg_wdata[`SACS_FLD_CONV_OFF];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			fault_latch_disable_reg <= 1'b0;
		else if (wr_dev)
			fault_latch_disable_reg <= reg_wdata[`SACS_FLD_FLT_LATCH];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`SACS_OFS_CONV_SETUP: reg_rdata <= {`SACS_CONV_RSVD, cfg_reg.rate_sel,
					cfg_reg.drop_off, cfg_reg.outv_off, cfg_reg.temp_off,
					cfg_reg.curr_off, cfg_reg.supply_off, cfg_reg.conv_off};
				`SACS_OFS_SUPPLY_RES: reg_rdata <= {`SACS_SUPPLY_RSVD, fresh_reg,
					supply_res_reg};
				`SACS_OFS_DEV_SETUP:  reg_rdata <= {15'h0000, fault_latch_disable_reg};
				default:              reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Supply result and fresh flag
	// ----------------------------------------------------------------
	wire logic supply_done = conv_done && conv_req.valid && conv_req.meas == SACS_M_SUPPLY;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			supply_res_reg <= 10'h000;
		else if (supply_done)
			supply_res_reg <= supply_result;
	end

	// Set wins over read-clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			fresh_reg <= 1'b0;
		else if (supply_done)
			fresh_reg <= 1'b1; // R11
		else if (rd_sup)
			fresh_reg <= 1'b0; // R11
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			supply_result_fresh <= 1'b0;
		else
			supply_result_fresh <= supply_done ? 1'b1 : (rd_sup ? 1'b0 : fresh_reg);
	end

	// ----------------------------------------------------------------
	// Global fault-type flags
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			flags_reg <= 6'h00;
		else if (fault_latch_disable_reg)
			flags_reg <= fault_live; // R2
		else if (fault_flag_rd)
			flags_reg <= fault_live; // R1
		else
			flags_reg <= flags_reg | fault_live; // R1
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			fault_flags <= 6'h00;
		else if (fault_latch_disable_reg || fault_flag_rd)
			fault_flags <= fault_live;
		else
			fault_flags <= flags_reg | fault_live;
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	function automatic logic meas_on(sacs_meas_t m, sacs_cfg_t c);
		case (m)
			SACS_M_DROP:   meas_on = !c.drop_off; // R4
			SACS_M_OUTV:   meas_on = !c.outv_off; // R6
			SACS_M_TEMP:   meas_on = !c.temp_off; // R7
			SACS_M_CURR:   meas_on = !c.curr_off; // R8
			SACS_M_SUPPLY: meas_on = !c.supply_off; // R9
			default:       meas_on = 1'b0;
		endcase
	endfunction : meas_on

	function automatic sacs_meas_t meas_succ(sacs_meas_t m);
		case (m)
			SACS_M_DROP:   meas_succ = SACS_M_OUTV;
			SACS_M_OUTV:   meas_succ = SACS_M_TEMP;
			SACS_M_TEMP:   meas_succ = SACS_M_CURR;
			SACS_M_CURR:   meas_succ = SACS_M_SUPPLY;
			default:       meas_succ = SACS_M_DROP;
		endcase
	endfunction : meas_succ

	// Channel off bits only matter when global bit clear
	function automatic logic [1:0] chan_of(sacs_meas_t m);
		case (m)
			SACS_M_DROP:   chan_of = ~drop_sense_channel_off; // R5
			SACS_M_OUTV:   chan_of = ~outvolt_sense_channel_off; // R5
			SACS_M_CURR:   chan_of = ~load_current_channel_off; // R5
			SACS_M_TEMP:   chan_of = 2'h3;
			default:       chan_of = 2'h0;
		endcase
	endfunction : chan_of

	// Current slots are stretched by the rate divider
	function automatic logic [`SACS_CNT_W+1:0] slot_len(sacs_meas_t m, logic [1:0] r);
		logic [`SACS_CNT_W+1:0] base;
		base = (`SACS_CNT_W+2)'(SLOT_CYC);
		if (m != SACS_M_CURR || r < 2'h2)
			slot_len = base; // R3
		else if (r == 2'h2)
			slot_len = base << 1; // R3
		else
			slot_len = base << 2; // R3
	endfunction : slot_len

	sacs_meas_t             cur_reg;
	sacs_meas_t             cand;
	logic                   any_on;
	logic [`SACS_CNT_W+1:0] cnt_reg;

	always_comb begin
		cand   = meas_succ(cur_reg);
		any_on = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (!any_on && meas_on(cand, cfg_reg))
				any_on = 1'b1;
			else if (!any_on)
				cand = meas_succ(cand);
		end
	end

	// A slot whose type was just excluded ends at once
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cur_reg  <= SACS_M_SUPPLY;
			cnt_reg  <= '0;
			conv_req <= '0;
		end else if (cfg_reg.conv_off || !any_on) begin
			cnt_reg  <= '0; // R10
			conv_req <= '0; // R12
		end else if (cnt_reg == '0 || !meas_on(cur_reg, cfg_reg)) begin
			cur_reg        <= cand; // R12
			cnt_reg        <= slot_len(cand, cfg_reg.rate_sel) - 1'b1;
			conv_req.valid <= 1'b1;
			conv_req.meas  <= cand;
			conv_req.chan_mask <= chan_of(cand);
		end else begin
			cnt_reg        <= cnt_reg - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_conv_off_idle;
		@(posedge mclk) disable iff (!rstn) cfg_reg.conv_off |=> !conv_req.valid;
	endproperty
	a_conv_off_idle: assert property (p_conv_off_idle) else $error("conversion while off"); // R10

	property p_slot_run;
		@(posedge mclk) disable iff (!rstn)
		!cfg_reg.conv_off && any_on |=> conv_req.valid;
	endproperty
	a_slot_run: assert property (p_slot_run) else $error("sequencer stalled"); // R12

	property p_no_drop;
		@(posedge mclk) disable iff (!rstn)
		cfg_reg.drop_off && $stable(cfg_reg) |=> !(conv_req.valid && conv_req.meas == SACS_M_DROP);
	endproperty
	a_no_drop: assert property (p_no_drop) else $error("drop sense while excluded"); // R4

	property p_no_outv;
		@(posedge mclk) disable iff (!rstn)
		cfg_reg.outv_off && $stable(cfg_reg) |=> !(conv_req.valid && conv_req.meas == SACS_M_OUTV);
	endproperty
	a_no_outv: assert property (p_no_outv) else $error("outvolt sense while excluded"); // R6

	property p_no_temp;
		@(posedge mclk) disable iff (!rstn)
		cfg_reg.temp_off && $stable(cfg_reg) |=> !(conv_req.valid && conv_req.meas == SACS_M_TEMP);
	endproperty
	a_no_temp: assert property (p_no_temp) else $error("temp sense while excluded"); // R7

	property p_no_curr;
		@(posedge mclk) disable iff (!rstn)
		cfg_reg.curr_off && $stable(cfg_reg) |=> !(conv_req.valid && conv_req.meas == SACS_M_CURR);
	endproperty
	a_no_curr: assert property (p_no_curr) else $error("current sense while excluded"); // R8

	property p_no_supply;
		@(posedge mclk) disable iff (!rstn)
		cfg_reg.supply_off && $stable(cfg_reg)
			|=> !(conv_req.valid && conv_req.meas == SACS_M_SUPPLY);
	endproperty
	a_no_supply: assert property (p_no_supply) else $error("supply sense while excluded"); // R9

	property p_latch_hold;
		@(posedge mclk) disable iff (!rstn)
		!fault_latch_disable_reg && !fault_flag_rd && $past(!fault_flag_rd)
			&& $past(!fault_latch_disable_reg) |-> (fault_flags & $past(fault_flags)) == $past(fault_flags);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped"); // R1

	property p_live_follow;
		@(posedge mclk) disable iff (!rstn)
		fault_latch_disable_reg |=> fault_flags == $past(fault_live);
	endproperty
	a_live_follow: assert property (p_live_follow) else $error("flag not live"); // R2

	property p_fresh_set;
		@(posedge mclk) disable iff (!rstn) supply_done |=> supply_result_fresh;
	endproperty
	a_fresh_set: assert property (p_fresh_set) else $error("fresh flag not set"); // R11

	property p_chan_mask;
		@(posedge mclk) disable iff (!rstn)
		conv_req.valid && conv_req.meas == SACS_M_TEMP |-> conv_req.chan_mask == 2'h3;
	endproperty
	a_chan_mask: assert property (p_chan_mask) else $error("temp channel mask"); // R7

endmodule : sacs_top

// ===== tb/sacs_host.sv
// Host model that reaches the converter setup registers
`timescale 1ns/1ps
`include "sacs_defs.svh"
module sacs_host (
	input  wire logic                    mclk,
	output logic                         reg_wr,
	output logic                         reg_rd,
	output logic [`SACS_ADDR_W-1:0]      reg_addr,
	output logic [15:0]                  reg_wdata,
	input  wire logic [15:0]             reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
	end
	// --------------------------------
	// Bus cycles; released lines show the inverse
	// --------------------------------
	task automatic wr(input logic [`SACS_ADDR_W-1:0] a, input logic [15:0] dat);
		@(posedge mclk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = dat;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~dat;
	endtask : wr
	task automatic rd(input logic [`SACS_ADDR_W-1:0] a, output logic [15:0] dat);
		@(posedge mclk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		dat = reg_rdata;
	endtask : rd
endmodule : sacs_host

// ===== tb/tb_sacs_top.sv
// Self-checking bench for the converter setup block
`timescale 1ns/1ps
`include "sacs_defs.svh"
module tb_sacs_top
	import sacs_pkg::*;
;
	localparam int SC = 4;
	logic        mclk = 1'b0, rstn = 1'b0, reg_wr, reg_rd, fault_flag_rd = 1'b0;
	logic        conv_done = 1'b0, supply_result_fresh;
	logic [5:0]  reg_addr, fault_live = 6'h00, fault_flags;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [1:0]  drop_sense_channel_off = 2'h0, outvolt_sense_channel_off = 2'h0;
	logic [1:0]  load_current_channel_off = 2'h0;
	logic [9:0]  supply_result = 10'h000;
	logic [31:0] r;
	logic [4:0]  on;
	sacs_conv_t  conv_req;
	sacs_meas_t  p;
	int          n_mismatch = 0, tests_run = 0, cyc = 0, n, t, k;
	always #5 mclk = ~mclk;
	sacs_top #(.SLOT_CYC(SC)) sacs_top_inst (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.drop_sense_channel_off(drop_sense_channel_off),
		.outvolt_sense_channel_off(outvolt_sense_channel_off),
		.load_current_channel_off(load_current_channel_off), .fault_live(fault_live),
		.fault_flag_rd(fault_flag_rd), .conv_done(conv_done), .supply_result(supply_result),
		.conv_req(conv_req), .fault_flags(fault_flags),
		.supply_result_fresh(supply_result_fresh));
	sacs_host sacs_host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step
	task automatic wait_meas(input sacs_meas_t m);
		n = 0;
		while (!(conv_req.valid === 1'b1 && conv_req.meas === m) && n < 200) begin
			step();
			n++;
		end
	endtask : wait_meas
	task automatic wait_chg;
		p = conv_req.meas;
		n = 0;
		while (conv_req.meas === p && n < 200) begin
			step();
			n++;
		end
	endtask : wait_chg
	function automatic logic [15:0] cfg(input logic [4:0] en, input logic [1:0] rs);
		logic [15:0] w;
		w = {8'h00, rs, 6'h00};
		for (int i = 0; i < 5; i++) w[5-i] = ~en[i];
		return w;
	endfunction : cfg
	function automatic sacs_meas_t nxt(input sacs_meas_t c, input logic [4:0] en);
		int j;
		for (int i = 1; i <= 5; i++) begin
			j = (int'(c) + i) % 5;
			if (en[j]) return sacs_meas_t'(j);
		end
		return c;
	endfunction : nxt
	function automatic logic [15:0] slot_len(input logic [1:0] rs);
		return 16'(rs == 2'h3 ? SC * 4 : rs == 2'h2 ? SC * 2 : SC);
	endfunction : slot_len
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		void'($urandom(32'hE7688F78));
		repeat (3) @(posedge mclk);
		#1;
		rstn = 1'b1;
		sacs_host_inst.rd(6'h0A, d);
		chk("conv setup", 16'hFF3A, d);
		sacs_host_inst.rd(6'h0C, d);
		chk("dev setup", 16'h0000, d);
		sacs_host_inst.rd(6'h0B, d);
		chk("supply", 16'hF800, d);
		sacs_host_inst.rd(6'h3F, d);
		chk("unmapped", 16'h0000, d);
		chk("meas", 16'(SACS_M_CURR), 16'(conv_req.meas));
		$display("test reset done");
		for (t = 0; t < 6; t++) begin
			on = (t == 0) ? 5'h1F : 5'($urandom);
			if ($countones(on) < 2) on = 5'h11;
			r = $urandom;
			drop_sense_channel_off = r[9:8];
			outvolt_sense_channel_off = r[11:10];
			load_current_channel_off = r[13:12];
			sacs_host_inst.wr(6'h0A, cfg(on, r[1:0]));
			sacs_host_inst.rd(6'h0A, d);
			chk("conv setup", cfg(on, r[1:0]) | 16'hFF00, d);
			wait_chg();
			for (k = 0; k < 6; k++) begin
				p = conv_req.meas;
				wait_chg();
				chk("meas", 16'(nxt(p, on)), 16'(conv_req.meas));
				case (conv_req.meas)
					SACS_M_DROP: chk("mask", {14'h0, ~drop_sense_channel_off}, 16'(conv_req.chan_mask));
					SACS_M_OUTV: chk("mask", {14'h0, ~outvolt_sense_channel_off}, 16'(conv_req.chan_mask));
					SACS_M_CURR: chk("mask", {14'h0, ~load_current_channel_off}, 16'(conv_req.chan_mask));
					default: ;
				endcase
			end
		end
		sacs_host_inst.wr(6'h0A, 16'h003E);
		repeat (3) step();
		chk("valid", 16'h0000, 16'(conv_req.valid));
		sacs_host_inst.wr(6'h0A, 16'h0001);
		repeat (3) step();
		chk("valid", 16'h0000, 16'(conv_req.valid));
		$display("test sequence done");
		for (t = 0; t < 4; t++) begin
			sacs_host_inst.wr(6'h0A, cfg(5'b01100, 2'(t)));
			wait_meas(SACS_M_TEMP);
			wait_meas(SACS_M_CURR);
			for (k = 0; conv_req.meas === SACS_M_CURR && k < 100; k++) step();
			chk("rate", slot_len(2'(t)), 16'(k));
		end
		$display("test rate done");
		sacs_host_inst.wr(6'h0A, cfg(5'b10100, 2'h0));
		wait_meas(SACS_M_SUPPLY);
		r = $urandom;
		supply_result = r[9:0];
		conv_done = 1'b1;
		step();
		conv_done = 1'b0;
		step();
		chk("fresh", 16'h0001, 16'(supply_result_fresh));
		sacs_host_inst.rd(6'h0B, d);
		chk("supply", {5'h1F, 1'b1, r[9:0]}, d);
		sacs_host_inst.rd(6'h0B, d);
		chk("supply", {5'h1F, 1'b0, r[9:0]}, d);
		$display("test supply done");
		r = $urandom_range(63, 1);
		fault_live = r[5:0];
		step();
		fault_live = 6'h00;
		repeat (2) step();
		chk("flags", 16'(r[5:0]), 16'(fault_flags));
		fault_flag_rd = 1'b1;
		step();
		fault_flag_rd = 1'b0;
		step();
		chk("flags", 16'h0000, 16'(fault_flags));
		sacs_host_inst.wr(6'h0C, 16'h0001);
		fault_live = r[5:0];
		repeat (2) step();
		chk("flags", 16'(r[5:0]), 16'(fault_flags));
		fault_live = 6'h00;
		repeat (2) step();
		chk("flags", 16'h0000, 16'(fault_flags));
		sacs_host_inst.rd(6'h0C, d);
		chk("dev setup", 16'h0001, d);
		$display("test fault done");
		give_verdict();
	end
endmodule : tb_sacs_top
